/* File: common/bmu_pkg.sv */
// Shared constants and types of the bit manipulation unit.
// Assumes a 32-bit APB register bus and 36-bit accumulators.
package bmu_pkg;
  localparam int ACC_W = 36;
  localparam int AUX_W = 16;
  localparam int CNT_W = 6;
  // Register byte offsets.
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_PSW = 12'h008;
  localparam logic [11:0] OFS_ALF = 12'h00C;
  localparam logic [11:0] OFS_IMM = 12'h010;
  localparam logic [11:0] OFS_WAIT = 12'h014;
  localparam logic [11:0] OFS_ACC = 12'h020;
  localparam logic [11:0] OFS_ALT = 12'h030;
  localparam logic [11:0] OFS_AUX = 12'h040;
  localparam logic [11:0] OFS_END = 12'h050;
  // Field positions.
  localparam int ALF_LSB = 4;
  localparam int WAIT_EXT_BIT = 8;
  localparam int WAIT_W = 4;
  localparam int CMD_W = 9;
  localparam int HI_W = 4;
  // Reset values.
  localparam logic [ACC_W-1:0] ACC_RST = 36'h0_0000_0000;
  localparam logic [AUX_W-1:0] AUX_RST = 16'h0000;
  // Execution cycles and program words.
  localparam logic [CNT_W-1:0] CYC_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CYC_TWO = 6'h02;
  localparam logic [1:0] WORD_ONE = 2'h1;
  localparam logic [1:0] WORD_TWO = 2'h2;
  localparam logic [5:0] MAX_SHIFT = 6'h24;
  localparam logic [5:0] NORM_BIAS = 6'h04;
  typedef enum logic [4:0] {
    OP_ASR_IMM, OP_ASR_AUX, OP_ASR_ACC,
    OP_LSR_IMM, OP_LSR_AUX, OP_LSR_ACC,
    OP_ASL_IMM, OP_ASL_AUX, OP_ASL_ACC,
    OP_LSL_IMM, OP_LSL_AUX, OP_LSL_ACC,
    OP_EXP, OP_NORM,
    OP_EXTS_IMM, OP_EXTS_AUX,
    OP_EXTZ_IMM, OP_EXTZ_AUX,
    OP_INS_IMM, OP_INS_AUX,
    OP_SHUF0, OP_SHUF1
  } bmu_op_t;
  typedef struct packed {
    logic [1:0] aux;
    logic dst;
    logic src;
    bmu_op_t op;
  } bmu_cmd_t;
  typedef struct packed {
    logic math_overflow_flag;
    logic logical_overflow_flag;
    logic result_zero_flag;
    logic result_negative_flag;
  } bmu_psw_t;
  typedef struct packed {
    logic not_minus_one_flag;
    logic minus_one_flag;
    logic evenp;
    logic oddp;
  } bmu_alf_t;
  typedef enum logic {ST_IDLE, ST_EXEC} bmu_state_t;
endpackage

/* File: rtl/bmu_unit.sv */
// Bit manipulation unit: shifts, exponent, normalize, field ops and
// alternate accumulator shuffle, reached as an APB slave.
// Assumes a single 100 MHz pclk and an APB master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bmu_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output var bmu_pkg::bmu_psw_t psw_flags,
  output var bmu_pkg::bmu_alf_t unit_flags
);
  logic [bmu_pkg::ACC_W-1:0] acc_r [2];
  logic [bmu_pkg::ACC_W-1:0] alt_r [2];
  logic [bmu_pkg::AUX_W-1:0] aux_r [4];
  logic [bmu_pkg::AUX_W-1:0] imm_r;
  logic [bmu_pkg::WAIT_W-1:0] wait_r;
  logic ext_pc_r;
  bmu_pkg::bmu_cmd_t cmd_r;
  bmu_pkg::bmu_state_t state_r;
  logic [bmu_pkg::CNT_W-1:0] cnt_r;
  logic [1:0] words_r;
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic acc_phase;
  logic wr_en;
  logic cmd_wr;
  logic commit;
  logic [11:0] off;
  logic [bmu_pkg::ACC_W-1:0] src_v;
  logic [bmu_pkg::ACC_W-1:0] dst_v;
  logic [bmu_pkg::ACC_W-1:0] val_v;
  logic [bmu_pkg::ACC_W-1:0] res_nxt;
  logic [bmu_pkg::AUX_W-1:0] opnd;
  logic [bmu_pkg::AUX_W-1:0] norm_e;
  logic llv_nxt;
  logic [71:0] ext72;
  logic [5:0] sh_n;
  logic sh_ill;
  logic [5:0] exp_cnt;
  logic [7:0] fw;
  logic [7:0] fo;
  logic [8:0] fsum;
  logic f_ill;
  logic [bmu_pkg::ACC_W-1:0] fmask;
  logic [bmu_pkg::ACC_W-1:0] field;
  logic [5:0] fidx;
  logic [bmu_pkg::CNT_W-1:0] base_cyc;
  logic [1:0] op_words;
  bmu_pkg::bmu_cmd_t new_cmd;

  assign off = paddr;
  assign acc_phase = psel & penable & pready;
  assign wr_en = acc_phase & pwrite & ~pslverr;
  assign cmd_wr = wr_en & (off == bmu_pkg::OFS_CMD);
  assign commit = (state_r == bmu_pkg::ST_EXEC) & (cnt_r == bmu_pkg::CYC_ONE);
  assign new_cmd = bmu_pkg::bmu_cmd_t'(pwdata[bmu_pkg::CMD_W-1:0]);
  // Read data is held in the answer flop itself, so prdata stands
  // unchanged from the access cycle until the next setup cycle.

  // Operand fetch: both selectors pick one of the two working accumulators.
  always_comb begin
    src_v = acc_r[cmd_r.src];
    dst_v = acc_r[cmd_r.dst];
    unique case (cmd_r.op)
      bmu_pkg::OP_ASR_IMM, bmu_pkg::OP_LSR_IMM, bmu_pkg::OP_ASL_IMM,
      bmu_pkg::OP_LSL_IMM, bmu_pkg::OP_EXTS_IMM, bmu_pkg::OP_EXTZ_IMM,
      bmu_pkg::OP_INS_IMM: opnd = imm_r;
      bmu_pkg::OP_ASR_ACC, bmu_pkg::OP_LSR_ACC, bmu_pkg::OP_ASL_ACC,
      bmu_pkg::OP_LSL_ACC: opnd = src_v[31:16];
      default: opnd = aux_r[cmd_r.aux];
    endcase
    // Accumulator-amount forms shift the other accumulator by aS.
    val_v = src_v;
    if (cmd_r.op inside {bmu_pkg::OP_ASR_ACC, bmu_pkg::OP_LSR_ACC,
        bmu_pkg::OP_ASL_ACC, bmu_pkg::OP_LSL_ACC}) begin
      val_v = acc_r[~cmd_r.src];
    end
  end

  // Shift amount is a signed 16-bit word; negative or above 36 is illegal.
  always_comb begin
    sh_ill = opnd[15] | (opnd > {10'h000, bmu_pkg::MAX_SHIFT});
    sh_n = sh_ill ? 6'h00 : opnd[5:0];
  end

  // Redundant sign bits below bit 35.
  always_comb begin
    logic run;
    run = 1'b1;
    exp_cnt = 6'h00;
    for (int i = 34; i >= 0; i--) begin
      if (run && (val_v[i] == val_v[35])) begin
        exp_cnt = exp_cnt + 6'h01;
      end else begin
        run = 1'b0;
      end
    end
  end

  // Field decode: upper byte width, lower byte offset, both zero-extended.
  always_comb begin
    fw = opnd[15:8];
    fo = opnd[7:0];
    fsum = {1'b0, fw} + {1'b0, fo};
    f_ill = (fw == 8'h00) | (fsum > {3'h0, bmu_pkg::MAX_SHIFT});
    fmask = (fw >= {2'h0, bmu_pkg::MAX_SHIFT}) ? {bmu_pkg::ACC_W{1'b1}}
          : ~({bmu_pkg::ACC_W{1'b1}} << fw);
    field = (src_v >> fo) & fmask;
    fidx = f_ill ? 6'h00 : fw[5:0] - 6'h01;
  end

  // Result of the latched operation and its overflow.
  always_comb begin
    logic signed [bmu_pkg::ACC_W-1:0] sv;
    logic [5:0] e;
    sv = val_v;
    e = exp_cnt - bmu_pkg::NORM_BIAS;
    res_nxt = val_v;
    llv_nxt = 1'b0;
    norm_e = {{10{e[5]}}, e};
    ext72 = 72'h0;
    unique case (cmd_r.op)
      bmu_pkg::OP_ASR_IMM, bmu_pkg::OP_ASR_AUX, bmu_pkg::OP_ASR_ACC: begin
        res_nxt = sv >>> sh_n;
        llv_nxt = sh_ill;
      end
      bmu_pkg::OP_LSR_IMM, bmu_pkg::OP_LSR_AUX, bmu_pkg::OP_LSR_ACC: begin
        res_nxt = {4'h0, val_v[31:0] >> sh_n};
        llv_nxt = sh_ill;
      end
      bmu_pkg::OP_ASL_IMM, bmu_pkg::OP_ASL_AUX, bmu_pkg::OP_ASL_ACC: begin
        ext72 = {{bmu_pkg::ACC_W{val_v[35]}}, val_v} << sh_n;
        res_nxt = ext72[35:0];
        llv_nxt = sh_ill | ~((&ext72[71:35]) | ~(|ext72[71:35]));
      end
      bmu_pkg::OP_LSL_IMM, bmu_pkg::OP_LSL_AUX, bmu_pkg::OP_LSL_ACC: begin
        ext72 = {{bmu_pkg::ACC_W{1'b0}}, val_v} << sh_n;
        res_nxt = ext72[35:0];
        llv_nxt = sh_ill | (|ext72[71:36]);
      end
      bmu_pkg::OP_EXP: begin
        res_nxt = {30'h0, exp_cnt};
      end
      bmu_pkg::OP_NORM: begin
        // Negative exponent means the value spills into the guard bits.
        // Both arms stay signed, or the right shift would lose its sign fill.
        res_nxt = e[5] ? (sv >>> (~e + 6'h01)) : (sv <<< e);
      end
      bmu_pkg::OP_EXTS_IMM, bmu_pkg::OP_EXTS_AUX: begin
        res_nxt = field[fidx] ? (field | ~fmask) : field;
        llv_nxt = f_ill;
      end
      bmu_pkg::OP_EXTZ_IMM, bmu_pkg::OP_EXTZ_AUX: begin
        res_nxt = field;
        llv_nxt = f_ill;
      end
      bmu_pkg::OP_INS_IMM, bmu_pkg::OP_INS_AUX: begin
        res_nxt = (dst_v & ~(fmask << fo)) | ((src_v & fmask) << fo);
        llv_nxt = f_ill;
      end
      bmu_pkg::OP_SHUF0: res_nxt = alt_r[0];
      bmu_pkg::OP_SHUF1: res_nxt = alt_r[1];
    endcase
  end

  // Base cycles and program words of an issued command.
  always_comb begin
    base_cyc = bmu_pkg::CYC_TWO;
    op_words = bmu_pkg::WORD_ONE;
    unique case (new_cmd.op)
      bmu_pkg::OP_ASR_AUX, bmu_pkg::OP_LSR_AUX, bmu_pkg::OP_ASL_AUX,
      bmu_pkg::OP_LSL_AUX, bmu_pkg::OP_EXP, bmu_pkg::OP_NORM,
      bmu_pkg::OP_EXTS_AUX, bmu_pkg::OP_EXTZ_AUX, bmu_pkg::OP_SHUF0,
      bmu_pkg::OP_SHUF1: base_cyc = bmu_pkg::CYC_ONE;
      bmu_pkg::OP_ASR_IMM, bmu_pkg::OP_LSR_IMM, bmu_pkg::OP_ASL_IMM,
      bmu_pkg::OP_LSL_IMM, bmu_pkg::OP_EXTS_IMM, bmu_pkg::OP_EXTZ_IMM,
      bmu_pkg::OP_INS_IMM: op_words = bmu_pkg::WORD_TWO;
      default: base_cyc = bmu_pkg::CYC_TWO;
    endcase
  end

  // Read data and error, prepared in the setup cycle.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (off[1:0] != 2'h0 || off >= bmu_pkg::OFS_END) begin
      err_nxt = 1'b1;
    end else if (off >= bmu_pkg::OFS_AUX) begin
      rd_nxt = {16'h0000, aux_r[off[3:2]]};
    end else if (off >= bmu_pkg::OFS_ALT) begin
      rd_nxt = off[2] ? {28'h0, alt_r[off[3]][35:32]} : alt_r[off[3]][31:0];
    end else if (off >= bmu_pkg::OFS_ACC) begin
      rd_nxt = off[2] ? {28'h0, acc_r[off[3]][35:32]} : acc_r[off[3]][31:0];
    end else begin
      unique case (off)
        bmu_pkg::OFS_CMD: rd_nxt = {23'h0, cmd_r};
        bmu_pkg::OFS_STAT: rd_nxt = {29'h0, words_r, state_r == bmu_pkg::ST_EXEC};
        bmu_pkg::OFS_PSW: rd_nxt = {28'h0, psw_flags};
        bmu_pkg::OFS_ALF: rd_nxt = {24'h0, unit_flags, 4'h0};
        bmu_pkg::OFS_IMM: rd_nxt = {16'h0000, imm_r};
        bmu_pkg::OFS_WAIT: rd_nxt = {23'h0, ext_pc_r, 4'h0, wait_r};
        default: err_nxt = 1'b1;
      endcase
    end
    // Writes while busy and unknown opcodes are refused.
    if (pwrite && (state_r == bmu_pkg::ST_EXEC)) begin
      err_nxt = 1'b1;
    end
    if (pwrite && off == bmu_pkg::OFS_CMD && pwdata[4:0] > 5'h15) begin
      err_nxt = 1'b1;
    end
  end

  // APB handshake: one wait-free access cycle after each setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        pslverr <= err_nxt;
        prdata <= err_nxt ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // Sequencer: counts base cycles plus external wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= bmu_pkg::ST_IDLE;
      cnt_r <= 6'h00;
      cmd_r <= bmu_pkg::bmu_cmd_t'(9'h000);
      words_r <= 2'h0;
      busy <= 1'b0;
    end else if (cmd_wr) begin
      state_r <= bmu_pkg::ST_EXEC;
      cmd_r <= new_cmd;
      words_r <= op_words;
      busy <= 1'b1;
      // Both factors widen to the counter width before the product is formed.
      cnt_r <= base_cyc + (ext_pc_r ? (6'(wait_r) * 6'(op_words)) : 6'h00);
    end else if (commit) begin
      state_r <= bmu_pkg::ST_IDLE;
      busy <= 1'b0;
      cnt_r <= 6'h00;
    end else if (state_r == bmu_pkg::ST_EXEC) begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

  // With at most 15 wait states on each of two words a command runs for no
  // more than 32 cycles, so the 6-bit counter never wraps.

  // Immediate and wait-state configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_r <= bmu_pkg::AUX_RST;
      wait_r <= 4'h0;
      ext_pc_r <= 1'b0;
    end else if (wr_en && off == bmu_pkg::OFS_IMM) begin
      imm_r <= pwdata[15:0];
    end else if (wr_en && off == bmu_pkg::OFS_WAIT) begin
      wait_r <= pwdata[3:0];
      ext_pc_r <= pwdata[bmu_pkg::WAIT_EXT_BIT];
    end
  end

  // Status flags after each unit operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_flags <= bmu_pkg::bmu_psw_t'(4'h0);
    end else if (commit) begin
      psw_flags.result_negative_flag <= res_nxt[35];
      psw_flags.result_zero_flag <= (res_nxt == 36'h0_0000_0000);
      psw_flags.logical_overflow_flag <= llv_nxt;
      psw_flags.math_overflow_flag <= ~((&res_nxt[35:31]) | ~(|res_nxt[35:31]));
    end
  end

  // Unit flags; an operation's result wins over a bus write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_flags <= bmu_pkg::bmu_alf_t'(4'h0);
    end else if (commit) begin
      unit_flags.oddp <= ^res_nxt;
      unit_flags.evenp <= ~(^res_nxt);
      unit_flags.minus_one_flag <= &res_nxt;
      unit_flags.not_minus_one_flag <= ~(&res_nxt);
    end else if (wr_en && off == bmu_pkg::OFS_ALF) begin
      unit_flags <= bmu_pkg::bmu_alf_t'(pwdata[bmu_pkg::ALF_LSB+:4]);
    end
  end

  // Per-entry storage of accumulators, alternates and aux registers.
  for (genvar k = 0; k < 4; k++) begin : g_reg
    logic [11:0] ofs_aux;
    assign ofs_aux = bmu_pkg::OFS_AUX + 12'(4 * k);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        aux_r[k] <= bmu_pkg::AUX_RST;
      end else if (commit && cmd_r.op == bmu_pkg::OP_NORM && cmd_r.aux == 2'(k)) begin
        aux_r[k] <= norm_e;
      end else if (wr_en && off == ofs_aux) begin
        aux_r[k] <= pwdata[15:0];
      end
    end
    if (k < 2) begin : g_acc
      logic [11:0] ofs_a;
      logic [11:0] ofs_b;
      assign ofs_a = bmu_pkg::OFS_ACC + 12'(8 * k);
      assign ofs_b = bmu_pkg::OFS_ALT + 12'(8 * k);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_r[k] <= bmu_pkg::ACC_RST;
        end else if (commit && cmd_r.dst == 1'(k)) begin
          acc_r[k] <= res_nxt;
        end else if (wr_en && off == ofs_a) begin
          acc_r[k][31:0] <= pwdata;
        end else if (wr_en && off == ofs_a + 12'h004) begin
          acc_r[k][35:32] <= pwdata[3:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          alt_r[k] <= bmu_pkg::ACC_RST;
        end else if (commit && cmd_r.op == (k == 0 ? bmu_pkg::OP_SHUF0 : bmu_pkg::OP_SHUF1)) begin
          alt_r[k] <= src_v;
        end else if (wr_en && off == ofs_b) begin
          alt_r[k][31:0] <= pwdata;
        end else if (wr_en && off == ofs_b + 12'h004) begin
          alt_r[k][35:32] <= pwdata[3:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/bmu_unit_chk.sv */
// Concurrent checks on the ports of the bit manipulation unit.
// Assumes the bind at the foot places it inside every bmu_unit.
`timescale 1ns/1ps
`default_nettype none
module bmu_unit_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy,
  input wire bmu_pkg::bmu_psw_t psw_flags,
  input wire bmu_pkg::bmu_alf_t unit_flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A setup phase, and an access phase that completes.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // Bus answer timing and refused transfers.
  a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready is not a one cycle answer to setup");
  a_unmapped_err: assert property ((s_done and (paddr >= bmu_pkg::OFS_END)) |-> pslverr)
    else $error("unmapped access not refused");
  a_busy_err: assert property ((s_done and (pwrite && busy)) |-> pslverr)
    else $error("write while busy not refused");
  a_err_zero: assert property ((s_done and (pslverr && !pwrite)) |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Command launch and completion time.
  a_cmd_busy: assert property ((s_done and (pwrite && !pslverr && paddr == bmu_pkg::OFS_CMD)) |=> busy)
    else $error("accepted command did not raise busy");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("command ran too long");
  // Flags move only at a commit, or at a flag register write.
  a_psw_commit: assert property (!$stable(psw_flags) |-> $past(busy))
    else $error("status flags changed outside a commit");
  a_alf_commit: assert property (!$stable(unit_flags) |->
      $past(busy) || $past(psel && penable && pwrite && paddr == bmu_pkg::OFS_ALF))
    else $error("unit flags changed without cause");
  a_flag_pairs: assert property ($fell(busy) |->
      (unit_flags.oddp != unit_flags.evenp) && (unit_flags.minus_one_flag != unit_flags.not_minus_one_flag))
    else $error("unit flag pairs not complementary after commit");
  a_zero_sign: assert property (psw_flags.result_zero_flag |-> !psw_flags.result_negative_flag && !psw_flags.math_overflow_flag)
    else $error("zero result with sign or overflow flag");
endmodule
bind bmu_unit bmu_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy), .psw_flags(psw_flags), .unit_flags(unit_flags));
`default_nettype wire

/* File: verif/bmu_host.sv */
// APB master standing in for the core that issues unit commands.
// Assumes one clock; raises hung when an answer never comes.
`timescale 1ns/1ps
`default_nettype none
module bmu_host (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic hung
);
  // The bus is idle from time zero.
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hung = 1'h0;
  end
  // One transfer; the request holds until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    hung <= (n >= 50);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the bit manipulation unit.
// Assumes bmu_host as bus master and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {string nm; logic wr; logic err; logic [31:0] dat;} bmu_exp_t;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, busy, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [4:0] sh;
  bmu_pkg::bmu_psw_t psw_flags;
  bmu_pkg::bmu_alf_t unit_flags;
  bmu_exp_t exp_q[$];
  int err_total = 0;
  int cmp_count = 0;
  // The 100 MHz clock.
  always #5 pclk = ~pclk;
  bmu_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .psw_flags(psw_flags), .unit_flags(unit_flags));
  bmu_host u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .hung(hung));
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  // Notes the expected answer, then runs the transfer.
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er, input string nm);
    exp_q.push_back('{nm, w, er, d});
    u_host.xfer(w, a, d);
  endtask
  // Accumulator access by index: acc0, acc1, alt0, alt1; low word then high nibble.
  task automatic acc(input logic w, input logic [1:0] i, input logic [35:0] d, input string nm);
    logic [11:0] a;
    a = bmu_pkg::OFS_ACC + {7'h00, i, 3'h0};
    xf(w, a, d[31:0], 1'h0, nm);
    xf(w, a + 12'h004, {28'h0, d[35:32]}, 1'h0, nm);
  endtask
  // Issues a command, optionally pokes the bus while busy, and counts busy cycles.
  task automatic cmd(input bmu_pkg::bmu_op_t op, input logic s, input logic d, input logic [1:0] x,
      input int n_exp, input logic poke);
    bmu_pkg::bmu_cmd_t c;
    int n;
    c = '{x, d, s, op};
    xf(1'h1, bmu_pkg::OFS_CMD, {23'h0, c}, 1'h0, "cmd");
    n = 0;
    if (poke) begin
      xf(1'h1, bmu_pkg::OFS_AUX, 32'h0000FFFF, 1'h1, "busy write");
      n = 3;
    end
    do begin
      @(posedge pclk);
      if (busy === 1'h1) n++;
    end while (busy === 1'h1 && n < 60);
    if (n >= 60) begin
      err_total++;
      results();
    end
    chk("cycles", 36'(n), 36'(n_exp));
  endtask
  // Scoreboard: each completed transfer takes the oldest note.
  always @(posedge pclk) begin
    bmu_exp_t e;
    if (hung === 1'h1) begin
      err_total++;
      results();
    end
    if (psel && penable && pready === 1'h1) begin
      e = exp_q.pop_front();
      chk({e.nm, " error"}, {35'h0, pslverr}, {35'h0, e.err});
      if (!e.wr) chk(e.nm, {4'h0, prdata}, {4'h0, e.dat});
    end
  end
  // Main sequence.
  initial begin
    v = $urandom(46994);
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    xf(1'h0, bmu_pkg::OFS_ALF, 32'h0, 1'h0, "alf");
    acc(1'h0, 2'h0, 36'h0, "acc0");
    xf(1'h0, bmu_pkg::OFS_END, 32'h0, 1'h1, "unmapped");
    xf(1'h1, bmu_pkg::OFS_CMD, 32'h16, 1'h1, "bad op");
    xf(1'h1, bmu_pkg::OFS_ALF, 32'h50, 1'h0, "alf");
    xf(1'h0, bmu_pkg::OFS_ALF, 32'h50, 1'h0, "alf");
    done("reset");
    acc(1'h1, 2'h0, 36'h8_0000_0010, "acc0");
    xf(1'h1, bmu_pkg::OFS_AUX, 32'h4, 1'h0, "aux0");
    cmd(bmu_pkg::OP_ASR_AUX, 1'h0, 1'h1, 2'h0, 1, 1'h0);
    acc(1'h0, 2'h1, 36'hF_8000_0001, "acc1");
    xf(1'h0, bmu_pkg::OFS_PSW, 32'h1, 1'h0, "psw");
    xf(1'h0, bmu_pkg::OFS_ALF, 32'hA0, 1'h0, "alf");
    chk("psw port", {32'h0, psw_flags}, 36'h1);
    chk("flag port", {32'h0, unit_flags}, 36'hA);
    done("asr");
    repeat (4) begin
      v = $urandom;
      sh = 5'($urandom_range(31, 0));
      acc(1'h1, 2'h0, {4'h0, v}, "acc0");
      xf(1'h1, bmu_pkg::OFS_AUX + 12'h004, {27'h0, sh}, 1'h0, "aux1");
      cmd(bmu_pkg::OP_LSR_AUX, 1'h0, 1'h0, 2'h1, 1, 1'h0);
      acc(1'h0, 2'h0, {4'h0, v >> sh}, "acc0");
    end
    done("lsr");
    acc(1'h1, 2'h1, 36'h8_0000_0001, "acc1");
    xf(1'h1, bmu_pkg::OFS_IMM, 32'h1, 1'h0, "imm");
    cmd(bmu_pkg::OP_LSL_IMM, 1'h1, 1'h0, 2'h0, 2, 1'h0);
    acc(1'h0, 2'h0, 36'h2, "acc0");
    xf(1'h0, bmu_pkg::OFS_PSW, 32'h4, 1'h0, "psw");
    done("lsl");
    acc(1'h1, 2'h0, 36'h0_0004_0000, "acc0");
    acc(1'h1, 2'h1, 36'h0_8000_0001, "acc1");
    cmd(bmu_pkg::OP_ASL_ACC, 1'h0, 1'h1, 2'h0, 2, 1'h0);
    acc(1'h0, 2'h1, 36'h8_0000_0010, "acc1");
    xf(1'h0, bmu_pkg::OFS_PSW, 32'hD, 1'h0, "psw");
    done("asl");
    acc(1'h1, 2'h0, 36'hF50, "acc0");
    xf(1'h1, bmu_pkg::OFS_AUX + 12'h008, 32'h0408, 1'h0, "aux2");
    cmd(bmu_pkg::OP_EXTS_AUX, 1'h0, 1'h1, 2'h2, 1, 1'h0);
    acc(1'h0, 2'h1, 36'hF_FFFF_FFFF, "acc1");
    xf(1'h0, bmu_pkg::OFS_ALF, 32'h60, 1'h0, "alf");
    xf(1'h1, bmu_pkg::OFS_IMM, 32'h0408, 1'h0, "imm");
    cmd(bmu_pkg::OP_EXTZ_IMM, 1'h0, 1'h1, 2'h0, 2, 1'h0);
    acc(1'h0, 2'h1, 36'hF, "acc1");
    acc(1'h1, 2'h0, 36'h5, "acc0");
    acc(1'h1, 2'h1, 36'hFF, "acc1");
    cmd(bmu_pkg::OP_INS_AUX, 1'h0, 1'h1, 2'h2, 2, 1'h0);
    acc(1'h0, 2'h1, 36'h5FF, "acc1");
    done("field");
    acc(1'h1, 2'h0, 36'h1, "acc0");
    cmd(bmu_pkg::OP_EXP, 1'h0, 1'h1, 2'h0, 1, 1'h0);
    acc(1'h0, 2'h1, 36'h22, "acc1");
    cmd(bmu_pkg::OP_NORM, 1'h0, 1'h1, 2'h3, 1, 1'h0);
    acc(1'h0, 2'h1, 36'h0_4000_0000, "acc1");
    xf(1'h0, bmu_pkg::OFS_AUX + 12'h00C, 32'h1E, 1'h0, "aux3");
    acc(1'h1, 2'h0, 36'h1_2345_6789, "acc0");
    acc(1'h1, 2'h3, 36'hAB, "alt1");
    cmd(bmu_pkg::OP_SHUF1, 1'h0, 1'h1, 2'h0, 1, 1'h0);
    acc(1'h0, 2'h1, 36'hAB, "acc1");
    acc(1'h0, 2'h3, 36'h1_2345_6789, "alt1");
    done("exp shuffle");
    xf(1'h1, bmu_pkg::OFS_WAIT, 32'h105, 1'h0, "wait");
    xf(1'h1, bmu_pkg::OFS_IMM, 32'h30, 1'h0, "imm");
    cmd(bmu_pkg::OP_ASR_IMM, 1'h0, 1'h0, 2'h0, 12, 1'h1);
    acc(1'h0, 2'h0, 36'h1_2345_6789, "acc0");
    xf(1'h0, bmu_pkg::OFS_PSW, 32'hC, 1'h0, "psw");
    xf(1'h0, bmu_pkg::OFS_AUX, 32'h4, 1'h0, "aux0");
    done("illegal shift");
    results();
  end
endmodule
`default_nettype wire
